// [logic/tbp_port.sv]
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tbp_port (
   input  wire logic       clk,                  // System clock, 200 MHz
   input  wire logic       nrst,                 // Synchronous reset, active low
   input  wire logic [7:0] addr,                 // Register address
   input  wire logic [7:0] wdata,                // Write data
   input  wire logic       wr,                   // Write strobe
   input  wire logic       rd,                   // Read strobe
   output logic      [7:0] rdata,                // Read data, cycle after rd
   input  wire logic       twowire_unit_enable,  // Two-wire unit on
   input  wire logic       clock_source_sel_hi,  // Serial clock source, high bit
   input  wire logic       clock_source_sel_lo,  // Serial clock source, low bit
   input  wire logic       sync_mode_sel,        // Clocked serial mode
   input  wire logic       receiver_enable,      // Serial receiver on
   input  wire logic       transmitter_enable,   // Serial transmitter on
   input  wire logic       sw_standby,           // Software standby
   input  wire logic       serial_clock_out,     // Clock from the serial unit
   input  wire logic       serial_transmit,      // Transmit data from the serial unit
   input  wire logic       twowire_clock_drv_low,// Two-wire unit pulls clock low
   output logic            serial_clock_in,      // Synchronised clock pin level
   output logic            serial_receive,       // Synchronised receive pin level
   output logic            twowire_clock_in,     // Synchronised bus clock level
   input  wire logic [2:0] pin_i,                // Pin levels
   output logic      [2:0] pin_o,                // Pin output values
   output logic      [2:0] pin_oe_n              // Pin output enables, low drives
);
   typedef struct packed {
      logic [2:0] dir;
      logic [2:0] data;
      logic [7:0] rdata;
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] lvl;
      logic [2:0] po;
      logic [2:0] poe_n;
   } tbp_state_t;

   tbp_state_t q;
   tbp_state_t d;
   logic [2:0] rd_val;
   logic       ser_ok;

   always_comb begin
      d         = q;
      ser_ok    = !sw_standby;
      d.s1      = pin_i;
      d.s2      = q.s1;
      d.s3      = q.s2;
      for (int i = 0; i < tbp_pkg::NPINS; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.lvl[i] = q.s3[i];
         end
      end
      if (wr && addr == tbp_pkg::ADDR_DIR) begin
         d.dir = wdata[2:0];
      end
      if (wr && addr == tbp_pkg::ADDR_DATA) begin
         d.data = wdata[2:0];
      end
      for (int i = 0; i < tbp_pkg::NPINS; i++) begin
         rd_val[i] = q.dir[i] ? q.data[i] : q.lvl[i];
      end
      d.rdata = 8'h00;
      if (rd && addr == tbp_pkg::ADDR_DATA) begin
         d.rdata = tbp_pkg::RSV_ONES | {5'h00, rd_val};
      end else if (rd && addr == tbp_pkg::ADDR_DIR) begin
         d.rdata = tbp_pkg::RSV_ONES;                    // Write-only bits read as zero
      end
      // General I/O by default, then serial overrides
      for (int i = 0; i < tbp_pkg::NPINS; i++) begin
         d.po[i]    = q.data[i];
         d.poe_n[i] = !q.dir[i];
      end
      if (twowire_unit_enable) begin
         // Open drain: drive zero only while pulling low
         d.po[tbp_pkg::PIN_CLK]    = 1'h0;
         d.poe_n[tbp_pkg::PIN_CLK] = !twowire_clock_drv_low;
      end else if (ser_ok && clock_source_sel_hi) begin
         d.poe_n[tbp_pkg::PIN_CLK] = 1'h1;
      end else if (ser_ok && (clock_source_sel_lo || sync_mode_sel)) begin
         d.po[tbp_pkg::PIN_CLK]    = serial_clock_out;
         d.poe_n[tbp_pkg::PIN_CLK] = 1'h0;
      end                                                // Else general I/O
      if (ser_ok && receiver_enable) begin
         d.poe_n[tbp_pkg::PIN_RX] = 1'h1;
      end
      if (ser_ok && transmitter_enable) begin
         d.po[tbp_pkg::PIN_TX]    = serial_transmit;
         d.poe_n[tbp_pkg::PIN_TX] = 1'h0;
      end
      if (!nrst) begin
         d       = '0;
         d.dir   = tbp_pkg::DIR_RESET;
         d.data  = tbp_pkg::DATA_RESET;
         d.poe_n = 3'h7;
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   assign rdata            = q.rdata;
   assign pin_o            = q.po;
   assign pin_oe_n         = q.poe_n;
   assign serial_clock_in  = q.lvl[tbp_pkg::PIN_CLK];
   assign twowire_clock_in = q.lvl[tbp_pkg::PIN_CLK];
   assign serial_receive   = q.lvl[tbp_pkg::PIN_RX];

   a_reset_inputs: assert property (@(posedge clk) !nrst |=> pin_oe_n == 3'h7)
      else $error("pins not inputs after reset");
   a_out_readback: assert property (@(posedge clk) disable iff (!nrst)
      rd && addr == tbp_pkg::ADDR_DATA && q.dir[0] |=> rdata[0] == $past(q.data[0]))
      else $error("output bit readback wrong");
   a_in_readback: assert property (@(posedge clk) disable iff (!nrst)
      rd && addr == tbp_pkg::ADDR_DATA && !q.dir[1] |=> rdata[1] == $past(q.lvl[1]))
      else $error("input bit readback wrong");
   a_rsv_ones: assert property (@(posedge clk) disable iff (!nrst)
      rd && addr == tbp_pkg::ADDR_DATA |=> rdata[7:3] == 5'h1F)
      else $error("reserved bits not ones");
   a_twowire_od: assert property (@(posedge clk) disable iff (!nrst)
      twowire_unit_enable |=> pin_o[2] == 1'h0)
      else $error("bus clock drove high");
   a_clk_input: assert property (@(posedge clk) disable iff (!nrst)
      !twowire_unit_enable && clock_source_sel_hi && !sw_standby |=> pin_oe_n[2])
      else $error("clock input pin driven");
   a_tx_drive: assert property (@(posedge clk) disable iff (!nrst)
      transmitter_enable && !sw_standby |=> !pin_oe_n[0] && pin_o[0] == $past(serial_transmit))
      else $error("transmit not driven");
   a_rx_input: assert property (@(posedge clk) disable iff (!nrst)
      receiver_enable && !sw_standby |=> pin_oe_n[1])
      else $error("receive pin driven");
   a_gpio_pin2: assert property (@(posedge clk) disable iff (!nrst)
      !twowire_unit_enable && !clock_source_sel_hi && !clock_source_sel_lo && !sync_mode_sel
      |=> pin_oe_n[2] == !$past(q.dir[2]))
      else $error("pin 2 general direction wrong");
   a_standby_gpio: assert property (@(posedge clk) disable iff (!nrst)
      sw_standby && !twowire_unit_enable |=> pin_oe_n[0] == !$past(q.dir[0]))
      else $error("standby pin not general");

   c_twowire: cover property (@(posedge clk) twowire_unit_enable && twowire_clock_drv_low);
   c_clk_out: cover property (@(posedge clk) !twowire_unit_enable && sync_mode_sel);
   c_readback: cover property (@(posedge clk) rd && addr == tbp_pkg::ADDR_DATA);
endmodule : tbp_port
`default_nettype wire

// [logic/tbp_pkg.sv]
package tbp_pkg;
   localparam int          NPINS       = 3;
   localparam logic [7:0]  ADDR_DIR    = 8'h00;
   localparam logic [7:0]  ADDR_DATA   = 8'h01;
   localparam logic [7:0]  RSV_ONES    = 8'hF8;
   localparam logic [2:0]  DIR_RESET   = 3'h0;
   localparam logic [2:0]  DATA_RESET  = 3'h0;
   localparam int          PIN_CLK     = 2;
   localparam int          PIN_RX      = 1;
   localparam int          PIN_TX      = 0;
endpackage : tbp_pkg

// [tb/tbp_pins.sv]
`timescale 1ns/1ps
`default_nettype none
module tbp_pins (
   input  wire logic [2:0] pin_o,     // Design drive values
   input  wire logic [2:0] pin_oe_n,  // Design enables, low drives
   input  wire logic [2:0] ext_lvl,   // Board device levels
   input  wire logic [2:0] ext_en,    // Board device drives
   output logic      [2:0] pin_i      // Resolved pin levels
);
   // Pull-ups hold released lines high, as the bus clock line needs
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pin_i[i] = !pin_oe_n[i] ? pin_o[i] : (ext_en[i] ? ext_lvl[i] : 1'h1);
      end
   end
endmodule // tbp_pins
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
   logic       clk = 0, nrst = 0, wr = 0, rd = 0, sct = 1, sco = 1, dl = 1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [6:0] ctl = 7'h00;
   logic [2:0] ext = 3'h0, een = 3'h7, pin_i, pin_o, pin_oe_n;
   logic       sci, srx, tci;
   int         n_mismatch = 0, checks_done = 0;
   always #2.5 clk = ~clk;
   tbp_port u_tbp_port (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .twowire_unit_enable(ctl[6]), .clock_source_sel_hi(ctl[5]),
      .clock_source_sel_lo(ctl[4]), .sync_mode_sel(ctl[3]), .receiver_enable(ctl[2]),
      .transmitter_enable(ctl[1]), .sw_standby(ctl[0]), .serial_clock_out(sco),
      .serial_transmit(sct), .twowire_clock_drv_low(dl), .serial_clock_in(sci),
      .serial_receive(srx), .twowire_clock_in(tci), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_n(pin_oe_n));
   tbp_pins u_tbp_pins (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_lvl(ext), .ext_en(een),
      .pin_i(pin_i));
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd <= 1'h0;
      #1 `CHK(rdata, e)
   endtask
   // Waits past the input synchronisers before looking at the pins
   task automatic setc(input logic [6:0] c, input logic [2:0] oe, input logic [2:0] o);
      @(posedge clk);
      ctl <= c;
      repeat (6) @(posedge clk);
      #1 `CHK(pin_oe_n, oe)
      `CHK(pin_o & ~pin_oe_n, o)
   endtask
   task automatic close_out;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #5000 n_mismatch++;
      close_out;
   end
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'h1;
      rchk(tbp_pkg::ADDR_DIR, 8'hF8);
      ext <= 3'h5;
      repeat (6) @(posedge clk);
      rchk(tbp_pkg::ADDR_DATA, 8'hFD);
      @(posedge clk);
      #1 `CHK(rdata, 8'h00)
      rchk(8'h07, 8'h00);
      wreg(tbp_pkg::ADDR_DATA, 8'hFA);
      wreg(tbp_pkg::ADDR_DIR, 8'hFB);
      setc(7'h00, 3'h4, 3'h2);
      rchk(tbp_pkg::ADDR_DATA, 8'hFE);
      rchk(tbp_pkg::ADDR_DIR, 8'hF8);
      wreg(tbp_pkg::ADDR_DIR, 8'hF8);
      ext <= 3'h2;
      setc(7'h02, 3'h6, 3'h1);
      setc(7'h04, 3'h7, 3'h0);
      `CHK(srx, 1'h1)
      setc(7'h10, 3'h3, 3'h4);
      setc(7'h08, 3'h3, 3'h4);
      setc(7'h30, 3'h7, 3'h0);
      `CHK(sci, 1'h0)
      setc(7'h40, 3'h3, 3'h0);
      dl <= 1'h0;
      een <= 3'h3;
      setc(7'h40, 3'h7, 3'h0);
      `CHK(tci, 1'h1)
      setc(7'h03, 3'h7, 3'h0);
      wreg(tbp_pkg::ADDR_DIR, 8'hFF);
      setc(7'h03, 3'h0, 3'h2);
      // Mid-run reset must return every pin to input and clear the registers
      @(posedge clk);
      nrst <= 1'h0;
      repeat (3) @(posedge clk);
      nrst <= 1'h1;
      #1 `CHK(pin_oe_n, 3'h7)
      rchk(tbp_pkg::ADDR_DATA, 8'hF8);
      repeat (2) @(posedge clk);
      rchk(tbp_pkg::ADDR_DATA, 8'hFE);
      close_out;
   end
endmodule // tb_top
`default_nettype wire
